// ===== design/seb_sequencer.sv
// seb_sequencer: servo enable gating, alarm handling, brake release timing
// and dynamic brake selection, with a classic wishbone register slave.
// assumes motor_speed_i and prot_trip_i come from logic on clk_i; all
// discrete host inputs and the main power sense are raw pins.
//
// Register access over Wishbone and the register addresses are this design's own decisions.
`default_nettype none
module seb_sequencer #(
  parameter int unsigned CYC_PER_MS = seb_pkg::CYC_PER_MS
) (
  input wire logic clk_i, // system clock, 200 MHz
  input wire logic rst_i, // synchronous reset, high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic servo_enable_input_i, // host servo enable pin
  input wire logic alarm_clear_input_i, // host alarm clear pin
  input wire logic cw_overtravel_inhibit_i, // cw limit pin
  input wire logic ccw_overtravel_inhibit_i, // ccw limit pin
  input wire logic main_power_on_i, // main power sense pin
  input wire logic prot_trip_i, // protective function active
  input wire logic [15:0] motor_speed_i, // speed magnitude, r/min
  output logic motor_energize_o, // motor current allowed
  output logic brake_release_output_o, // high releases holding brake
  output logic servo_alarm_output_o, // high while in alarm
  output logic dyn_brake_o, // dynamic brake engaged
  output logic cmd_enable_o, // motion commands accepted
  output logic irq_o // level interrupt
);
  typedef enum logic [2:0] {
    S_INIT,
    S_OFF,
    S_ON,
    S_HOLD,
    S_COAST,
    S_ALARM,
    S_REARM,
    S_CMDWAIT
  } seb_state_e;
  // pick the dynamic-brake bit of one cause's two-bit field
  function automatic logic db_select(input logic [5:0] seq, input logic [1:0] cause,
                                     input logic slow);
    logic [1:0] fld;
    case (cause)
      seb_pkg::CAUSE_ALARM: fld = seq[seb_pkg::SEQ_ALARM_POS +: 2];
      seb_pkg::CAUSE_OVT: fld = seq[seb_pkg::SEQ_OVT_POS +: 2];
      default: fld = seq[seb_pkg::SEQ_SRVOFF_POS +: 2];
    endcase
    db_select = slow ? fld[seb_pkg::SEQ_STOP_BIT] : fld[seb_pkg::SEQ_DECEL_BIT];
  endfunction
  // merge write data into a 16-bit register through the two low byte lanes
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] wdat,
                                             input logic [1:0] sel);
    lane_merge = old;
    for (int i = 0; i < 2; i++) begin
      if (sel[i]) begin
        lane_merge[i*8 +: 8] = wdat[i*8 +: 8];
      end
    end
  endfunction
  // pin synchronisers
  logic [seb_pkg::PIN_W-1:0] pins_sync;
  seb_sync #(.WIDTH(seb_pkg::PIN_W)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({main_power_on_i, ccw_overtravel_inhibit_i, cw_overtravel_inhibit_i,
              alarm_clear_input_i, servo_enable_input_i}),
    .sync_o(pins_sync)
  );
  wire en_s = pins_sync[seb_pkg::PIN_EN];
  wire clr_s = pins_sync[seb_pkg::PIN_CLR];
  wire ovt_s = pins_sync[seb_pkg::PIN_CW] | pins_sync[seb_pkg::PIN_CCW];
  wire pwr_s = pins_sync[seb_pkg::PIN_PWR];
  wire slow = (motor_speed_i < seb_pkg::SLOW_RPM);
  // state and outputs
  seb_state_e state_ff, nxt_state;
  logic energize_ff, nxt_energize;
  logic release_ff, nxt_release;
  logic alarm_ff, nxt_alarm;
  logic cmd_ff, nxt_cmd;
  logic db_ff, nxt_db;
  logic alarm_path_ff, nxt_alarm_path;
  logic [1:0] cause_ff, nxt_cause;
  logic en_prev_ff, clr_prev_ff;
  logic ev_alarm, ev_cleared, ev_brake, ev_refused; // interrupt event strobes
  // software-visible settings
  logic [15:0] stop_dly_ff;
  logic [15:0] move_dly_ff;
  logic [5:0] seq_sel_ff;
  logic [3:0] irq_mask_ff;
  logic [3:0] irq_stat_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  // sequence timer and alarm-clear hold timer
  logic tmr_start, tmr_run, tmr_done;
  logic [15:0] tmr_dur;
  seb_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_seq_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(tmr_start),
    .stop_i(1'b0),
    .dur_ms_i(tmr_dur),
    .running_o(tmr_run),
    .done_o(tmr_done)
  );
  wire clr_rise = clr_s && !clr_prev_ff;
  logic clr_done;
  seb_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_clr_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(clr_rise),
    .stop_i(!clr_s),
    .dur_ms_i(seb_pkg::CLR_HOLD_MS),
    .running_o(),
    .done_o(clr_done)
  );
  // a clear is honoured only once held long enough and the trip is gone
  wire clr_ok = clr_done && clr_s && !prot_trip_i;
  // sequence next-state logic
  always_comb begin
    nxt_state = state_ff;
    nxt_energize = energize_ff;
    nxt_release = release_ff;
    nxt_alarm = alarm_ff;
    nxt_cmd = cmd_ff;
    nxt_alarm_path = alarm_path_ff;
    nxt_cause = cause_ff;
    tmr_start = 1'b0;
    tmr_dur = 16'h0000;
    ev_refused = 1'b0;
    case (state_ff)
      S_INIT: begin
        // enable is not looked at here at all
        if (tmr_done) begin
          nxt_state = S_OFF;
        end else if (!tmr_run) begin
          tmr_start = 1'b1;
          tmr_dur = seb_pkg::INIT_MS;
        end
      end
      S_OFF: begin
        if (prot_trip_i) begin
          nxt_alarm = 1'b1;
          nxt_cause = seb_pkg::CAUSE_ALARM;
          nxt_state = S_ALARM;
        end else if (en_s && pwr_s && slow) begin
          nxt_energize = 1'b1;
          nxt_release = 1'b1;
          nxt_cmd = 1'b1;
          nxt_cause = seb_pkg::CAUSE_SRVOFF;
          nxt_state = S_ON;
        end else if (en_s && !en_prev_ff) begin
          ev_refused = 1'b1;
        end
      end
      S_ON, S_CMDWAIT: begin
        if (prot_trip_i) begin
          nxt_energize = 1'b0;
          nxt_alarm = 1'b1;
          nxt_cmd = 1'b0;
          nxt_cause = seb_pkg::CAUSE_ALARM;
          if (slow) begin
            // already below threshold: the shorter time is zero
            nxt_release = 1'b0;
            nxt_state = S_ALARM;
          end else begin
            nxt_alarm_path = 1'b1;
            tmr_start = 1'b1;
            tmr_dur = move_dly_ff;
            nxt_state = S_COAST;
          end
        end else if (!en_s || !pwr_s) begin
          nxt_cmd = 1'b0;
          nxt_cause = seb_pkg::CAUSE_SRVOFF;
          nxt_alarm_path = 1'b0;
          tmr_start = 1'b1;
          if (slow) begin
            // brake first, current stays on for the stopped delay
            nxt_release = 1'b0;
            tmr_dur = stop_dly_ff;
            nxt_state = S_HOLD;
          end else begin
            nxt_energize = 1'b0;
            tmr_dur = move_dly_ff;
            nxt_state = S_COAST;
          end
        end else if (state_ff == S_CMDWAIT) begin
          if (tmr_done) begin
            nxt_cmd = 1'b1;
            nxt_state = S_ON;
          end
        end else begin
          // overtravel frees the motor; the field picks brake or coast
          nxt_energize = !ovt_s;
          nxt_cmd = !ovt_s;
          nxt_cause = ovt_s ? seb_pkg::CAUSE_OVT : seb_pkg::CAUSE_SRVOFF;
        end
      end
      S_HOLD: begin
        if (prot_trip_i) begin
          nxt_energize = 1'b0;
          nxt_alarm = 1'b1;
          nxt_cause = seb_pkg::CAUSE_ALARM;
          nxt_state = S_ALARM;
        end else if (tmr_done) begin
          nxt_energize = 1'b0;
          nxt_state = S_OFF;
        end
      end
      S_COAST: begin
        if (prot_trip_i && !alarm_path_ff) begin
          nxt_alarm = 1'b1;
          nxt_alarm_path = 1'b1;
          nxt_cause = seb_pkg::CAUSE_ALARM;
        end
        // whichever comes first: delay expiry or slowing down
        if (tmr_done || slow) begin
          nxt_release = 1'b0;
          nxt_state = (alarm_path_ff || prot_trip_i) ? S_ALARM : S_OFF;
        end
      end
      S_ALARM: begin
        if (clr_ok) begin
          nxt_alarm_path = 1'b0;
          if (en_s && pwr_s) begin
            tmr_start = 1'b1;
            tmr_dur = seb_pkg::REARM_MS;
            nxt_state = S_REARM;
          end else begin
            nxt_alarm = 1'b0;
            nxt_cause = seb_pkg::CAUSE_SRVOFF;
            nxt_state = S_OFF;
          end
        end
      end
      S_REARM: begin
        if (tmr_done) begin
          nxt_energize = 1'b1;
          nxt_release = 1'b1;
          nxt_alarm = 1'b0;
          nxt_cause = seb_pkg::CAUSE_SRVOFF;
          tmr_start = 1'b1;
          tmr_dur = seb_pkg::CMD_DLY_MS;
          nxt_state = S_CMDWAIT;
        end
      end
      default: begin
        nxt_state = S_INIT;
      end
    endcase
  end
  // dynamic brake: forced with main power off, else per cause field while de-energized
  assign nxt_db = !pwr_s || (!nxt_energize && db_select(seq_sel_ff, nxt_cause, slow));
  assign ev_alarm = nxt_alarm && !alarm_ff;
  assign ev_cleared = !nxt_alarm && alarm_ff;
  assign ev_brake = !nxt_release && release_ff;
  // sequencer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= S_INIT;
      energize_ff <= 1'b0;
      release_ff <= 1'b0;
      alarm_ff <= 1'b0;
      cmd_ff <= 1'b0;
      db_ff <= 1'b1;
      alarm_path_ff <= 1'b0;
      cause_ff <= seb_pkg::CAUSE_SRVOFF;
      en_prev_ff <= 1'b0;
      clr_prev_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      energize_ff <= nxt_energize;
      release_ff <= nxt_release;
      alarm_ff <= nxt_alarm;
      cmd_ff <= nxt_cmd;
      db_ff <= nxt_db;
      alarm_path_ff <= nxt_alarm_path;
      cause_ff <= nxt_cause;
      en_prev_ff <= en_s;
      clr_prev_ff <= clr_s;
    end
  end
  // main power loss removes current at once, whatever the state
  assign motor_energize_o = energize_ff && pwr_s;
  assign brake_release_output_o = release_ff;
  assign servo_alarm_output_o = alarm_ff;
  assign dyn_brake_o = db_ff;
  assign cmd_enable_o = cmd_ff;
  // bus decode: one ack per request, answered the cycle after the strobe
  wire wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
  wire wr_stop = wb_req && wb_we_i && (wb_adr_i == seb_pkg::OFS_STOP_DLY);
  wire wr_move = wb_req && wb_we_i && (wb_adr_i == seb_pkg::OFS_MOVE_DLY);
  wire wr_seq = wb_req && wb_we_i && (wb_adr_i == seb_pkg::OFS_SEQ_SEL);
  wire wr_mask = wb_req && wb_we_i && (wb_adr_i == seb_pkg::OFS_IRQ_MASK);
  wire rd_stat = wb_req && !wb_we_i && (wb_adr_i == seb_pkg::OFS_IRQ_STAT);
  wire [3:0] irq_events = {ev_refused, ev_brake, ev_cleared, ev_alarm};
  wire [31:0] status_word = {20'h00000, 1'b0, state_ff, cause_ff, cmd_ff, db_ff,
                             alarm_ff, release_ff, energize_ff, pwr_s};
  logic [31:0] rd_mux;
  always_comb begin
    case (wb_adr_i)
      seb_pkg::OFS_STOP_DLY: rd_mux = {16'h0000, stop_dly_ff};
      seb_pkg::OFS_MOVE_DLY: rd_mux = {16'h0000, move_dly_ff};
      seb_pkg::OFS_SEQ_SEL: rd_mux = {26'h0000000, seq_sel_ff};
      seb_pkg::OFS_STATUS: rd_mux = status_word;
      seb_pkg::OFS_IRQ_STAT: rd_mux = {28'h0000000, irq_stat_ff};
      seb_pkg::OFS_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  // register writes, byte-lane aware; unmapped writes are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stop_dly_ff <= seb_pkg::STOP_DLY_RST;
      move_dly_ff <= seb_pkg::MOVE_DLY_RST;
      seq_sel_ff <= seb_pkg::SEQ_SEL_RST;
      irq_mask_ff <= seb_pkg::IRQ_MASK_RST;
    end else begin
      if (wr_stop) begin
        stop_dly_ff <= lane_merge(stop_dly_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
      if (wr_move) begin
        move_dly_ff <= lane_merge(move_dly_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
      if (wr_seq && wb_sel_i[0]) begin
        seq_sel_ff <= wb_dat_i[5:0];
      end
      if (wr_mask && wb_sel_i[0]) begin
        irq_mask_ff <= wb_dat_i[3:0];
      end
    end
  end
  // sticky events; a new event beats the read that clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= 4'h0;
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      irq_stat_ff <= (rd_stat ? 4'h0 : irq_stat_ff) | irq_events;
      ack_ff <= wb_req;
      rdat_ff <= wb_req ? rd_mux : 32'h0000_0000;
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign irq_o = |(irq_stat_ff & irq_mask_ff);
endmodule // seb_sequencer
`default_nettype wire

// ===== design/seb_pkg.sv
// seb_pkg: shared constants of the servo enable / brake sequencer
// assumes a 200 MHz system clock and a 32-bit classic wishbone bus
`default_nettype none
package seb_pkg;
  // clock and time base
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
  // sequence times, in ms
  localparam logic [15:0] INIT_MS = 16'h0064;
  localparam logic [15:0] CLR_HOLD_MS = 16'h0078;
  localparam logic [15:0] REARM_MS = 16'h0028;
  localparam logic [15:0] CMD_DLY_MS = 16'h0064;
  // standstill threshold, r/min
  localparam logic [15:0] SLOW_RPM = 16'h001E;
  // register byte offsets
  localparam logic [7:0] OFS_STOP_DLY = 8'h00;
  localparam logic [7:0] OFS_MOVE_DLY = 8'h04;
  localparam logic [7:0] OFS_SEQ_SEL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  // reset values
  localparam logic [15:0] STOP_DLY_RST = 16'h0000;
  localparam logic [15:0] MOVE_DLY_RST = 16'h0064;
  localparam logic [5:0] SEQ_SEL_RST = 6'h3F;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  // stop-sequence field positions: two bits per cause
  localparam int unsigned SEQ_SRVOFF_POS = 0;
  localparam int unsigned SEQ_ALARM_POS = 2;
  localparam int unsigned SEQ_OVT_POS = 4;
  localparam int unsigned SEQ_DECEL_BIT = 0;
  localparam int unsigned SEQ_STOP_BIT = 1;
  // interrupt status bits
  localparam int unsigned IRQ_ALARM = 0;
  localparam int unsigned IRQ_CLEARED = 1;
  localparam int unsigned IRQ_BRAKE = 2;
  localparam int unsigned IRQ_REFUSED = 3;
  localparam int unsigned IRQ_W = 4;
  // synchronised pin bundle positions
  localparam int unsigned PIN_EN = 0;
  localparam int unsigned PIN_CLR = 1;
  localparam int unsigned PIN_CW = 2;
  localparam int unsigned PIN_CCW = 3;
  localparam int unsigned PIN_PWR = 4;
  localparam int unsigned PIN_W = 5;
  // stop cause codes
  typedef enum logic [1:0] {
    CAUSE_SRVOFF,
    CAUSE_ALARM,
    CAUSE_OVT
  } seb_cause_e;
endpackage
`default_nettype wire

// ===== design/seb_sync.sv
// seb_sync: two-flop synchroniser for a bundle of pin levels
// assumes inputs are quasi-static levels from outside the clock domain
`default_nettype none
module seb_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic [WIDTH-1:0] async_i, // raw pin levels
  output logic [WIDTH-1:0] sync_o // synchronised levels
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule // seb_sync
`default_nettype wire

// ===== design/seb_ms_timer.sv
// seb_ms_timer: millisecond down-counter with a cycle prescaler
// assumes start_i is a one-cycle pulse from same-domain logic
`default_nettype none
module seb_ms_timer #(
  parameter int unsigned CYC_PER_MS = seb_pkg::CYC_PER_MS
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic start_i, // load and arm
  input wire logic stop_i, // disarm
  input wire logic [15:0] dur_ms_i, // duration in ms
  output logic running_o, // armed and counting
  output logic done_o // armed and expired
);
  logic armed_ff;
  logic [15:0] left_ff;
  logic [31:0] pre_ff;
  wire pre_wrap = (pre_ff == 32'(CYC_PER_MS - 1));

  // restart loads the duration; a restart clears the prescaler phase
  always_ff @(posedge clk_i) begin
    if (rst_i || stop_i) begin
      armed_ff <= 1'b0;
      left_ff <= 16'h0000;
      pre_ff <= 32'h0000_0000;
    end else if (start_i) begin
      armed_ff <= 1'b1;
      left_ff <= dur_ms_i;
      pre_ff <= 32'h0000_0000;
    end else if (armed_ff && left_ff != 16'h0000) begin
      pre_ff <= pre_wrap ? 32'h0000_0000 : pre_ff + 32'h0000_0001;
      if (pre_wrap) begin
        left_ff <= left_ff - 16'h0001;
      end
    end
  end

  assign running_o = armed_ff && (left_ff != 16'h0000);
  assign done_o = armed_ff && (left_ff == 16'h0000);
endmodule // seb_ms_timer
`default_nettype wire

// ===== tb/seb_sequencer_chk.sv
// seb_sequencer_chk: port-level assertions on the sequencer
// assumes one clock domain and a synchronous active-high reset
`default_nettype none
module seb_sequencer_chk #(
  parameter int unsigned CYC_PER_MS = seb_pkg::CYC_PER_MS
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_ack_o, // bus ack
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic main_power_on_i, // power sense
  input wire logic [15:0] motor_speed_i, // speed r/min
  input wire logic motor_energize_o, // motor current
  input wire logic brake_release_output_o, // brake released
  input wire logic servo_alarm_output_o, // alarm
  input wire logic dyn_brake_o, // dynamic brake
  input wire logic cmd_enable_o // commands accepted
);
  localparam int unsigned INIT_CYC = int'(seb_pkg::INIT_MS) * CYC_PER_MS;
  logic [31:0] init_cnt_ff;
  logic [31:0] nxt_init_cnt;
  // saturating age counter, so it never wraps back into the init window
  assign nxt_init_cnt = (init_cnt_ff == 32'hFFFFFFFF) ? init_cnt_ff : init_cnt_ff + 32'h1;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_cnt_ff <= 32'h0;
    end else begin
      init_cnt_ff <= nxt_init_cnt;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_INIT_IGNORE: assert property (init_cnt_ff < INIT_CYC |->
    !motor_energize_o && !brake_release_output_o) else $error("energized during init");
  AST_REL_NEEDS_EN: assert property ($rose(brake_release_output_o) |->
    motor_energize_o) else $error("brake released while not energized");
  AST_CMD_READY: assert property ($rose(cmd_enable_o) |-> motor_energize_o &&
    brake_release_output_o && !servo_alarm_output_o) else $error("commands too early");
  AST_ALARM_OFF: assert property ($rose(servo_alarm_output_o) |->
    !motor_energize_o) else $error("alarm without de-energize");
  AST_PWR_DB: assert property (!main_power_on_i [*4] |-> dyn_brake_o)
    else $error("dynamic brake off without power");
  AST_FAST_HOLD: assert property (!motor_energize_o && motor_speed_i >= 16'h001E |=>
    !motor_energize_o) else $error("energized while still fast");
  AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  AST_WB_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  AST_WB_DAT_ZERO: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
endmodule // seb_sequencer_chk
bind seb_sequencer seb_sequencer_chk #(.CYC_PER_MS(CYC_PER_MS)) chk_u (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .main_power_on_i, .motor_speed_i,
  .motor_energize_o, .brake_release_output_o, .servo_alarm_output_o, .dyn_brake_o,
  .cmd_enable_o);
`default_nettype wire

// ===== tb/seb_host_model.sv
// seb_host_model: host pin driver plus a crude motor speed model
// assumes the bench sets commands; pins follow one edge later
`default_nettype none
module seb_host_model (
  input wire logic clk_i, // system clock
  input wire logic energize_i, // motor current from the sequencer
  input wire logic [5:0] cmd_i, // en, clr, cw, ccw, pwr, trip
  input wire logic [15:0] run_spd_i, // speed while energized
  input wire logic [15:0] step_i, // deceleration per cycle
  output logic [5:0] pins_o, // pin levels, same order
  output logic [15:0] spd_o // speed magnitude
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pins_o = 6'h11;
    spd_o = 16'h0000;
  end
  // the bench orders enable changes; the model only times them to an edge
  always @(posedge clk_i) begin
    pins_o <= cmd_i;
  end
  // coasting motor: speed only decays while not energized
  always @(posedge clk_i) begin
    if (energize_i) begin
      spd_o <= run_spd_i;
    end else if (spd_o > step_i) begin
      spd_o <= spd_o - step_i;
    end else begin
      spd_o <= 16'h0000;
    end
  end
endmodule // seb_host_model
`default_nettype wire

// ===== tb/seb_sequencer_tb.sv
// seb_sequencer_tb: register and pin sequence tests of the sequencer
// assumes CYC_PER_MS of 10, so one ms is ten clock cycles
`default_nettype none
module seb_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [5:0] cmd = 6'h11;
  logic [15:0] run_spd = 16'h0000;
  logic [15:0] step = 16'h0001;
  logic [5:0] pins;
  logic [15:0] spd;
  logic [31:0] rdat;
  logic ack, en_o, rel, servo_alarm_output, db, cmd_o, irq;
  logic [5:0] st;
  int fails = 0;
  int n_checks = 0;
  assign st = {irq, en_o, rel, servo_alarm_output, db, cmd_o};
  always #2.5 clk_i = ~clk_i;
  seb_host_model host_u (.clk_i(clk_i), .energize_i(en_o), .cmd_i(cmd), .run_spd_i(run_spd),
    .step_i(step), .pins_o(pins), .spd_o(spd));
  seb_sequencer #(.CYC_PER_MS(10)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .servo_enable_input_i(pins[0]),
    .alarm_clear_input_i(pins[1]), .cw_overtravel_inhibit_i(pins[2]),
    .ccw_overtravel_inhibit_i(pins[3]), .main_power_on_i(pins[4]), .prot_trip_i(pins[5]),
    .motor_speed_i(spd), .motor_energize_o(en_o), .brake_release_output_o(rel),
    .servo_alarm_output_o(servo_alarm_output), .dyn_brake_o(db), .cmd_enable_o(cmd_o), .irq_o(irq));
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one classic cycle; hold everything until ack is seen at an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1 && n < 64);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    if (n >= 64) begin
      fails++;
      $display("mismatch at %0t: bus timeout", $time);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'h1, a, d, q);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'h0, a, 32'h0, q);
    n_checks++;
    if (q !== e) begin
      fails++;
      $display("mismatch at %0t: read %h got %h exp %h", $time, a, q, e);
    end
  endtask
  // outputs as {irq, energize, release, alarm, dyn, cmd}, under a care mask
  task automatic chk_st(input logic [5:0] m, input logic [5:0] e);
    n_checks++;
    if ((st & m) !== e) begin
      fails++;
      $display("mismatch at %0t: pins got %h exp %h", $time, st & m, e);
    end
  endtask
  // sample at the falling edge, where registered outputs have settled
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic set(input int i, input logic v);
    @(posedge clk_i);
    cmd[i] <= v;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    tally_and_finish();
  end
  initial begin
    settle(2);
    chk_st(6'h3F, 6'h02);
    @(posedge clk_i);
    rst_i <= 1'h0;
    chk_rd(8'h00, 32'h0);
    chk_rd(8'h04, 32'h64);
    chk_rd(8'h08, 32'h3F);
    chk_rd(8'h14, 32'h0);
    chk_rd(8'h20, 32'h0);
    wr(8'h00, 32'h2);
    wr(8'h04, 32'h5);
    wr(8'h08, 32'h2C);
    wr(8'h14, 32'hF);
    chk_rd(8'h08, 32'h2C);
    settle(400);
    chk_st(6'h19, 6'h00);
    settle(700);
    chk_st(6'h3F, 6'h19);
    chk_rd(8'h0C, 32'h227);
    set(0, 1'h0);
    settle(10);
    chk_st(6'h18, 6'h10);
    settle(30);
    chk_st(6'h3A, 6'h20);
    chk_rd(8'h10, 32'h4);
    chk_st(6'h20, 6'h00);
    set(0, 1'h1);
    settle(15);
    chk_st(6'h10, 6'h10);
    run_spd <= 16'h03E8;
    settle(5);
    set(0, 1'h0);
    settle(10);
    chk_st(6'h1A, 6'h08);
    settle(30);
    chk_st(6'h08, 6'h08);
    settle(30);
    chk_st(6'h08, 6'h00);
    set(0, 1'h1);
    settle(20);
    chk_st(6'h10, 6'h00);
    chk_rd(8'h10, 32'hC);
    set(0, 1'h0);
    run_spd <= 16'h0000;
    settle(1000);
    set(0, 1'h1);
    settle(15);
    chk_st(6'h10, 6'h10);
    wr(8'h04, 32'h64);
    run_spd <= 16'h03E8;
    step <= 16'h0064;
    settle(5);
    set(5, 1'h1);
    settle(10);
    chk_st(6'h14, 6'h04);
    settle(20);
    chk_st(6'h1E, 6'h06);
    chk_rd(8'h10, 32'h5);
    set(5, 1'h0);
    run_spd <= 16'h0000;
    set(1, 1'h1);
    settle(1210);
    set(1, 1'h0);
    settle(360);
    chk_st(6'h14, 6'h04);
    settle(60);
    chk_st(6'h1F, 6'h18);
    settle(1000);
    chk_st(6'h1F, 6'h19);
    chk_rd(8'h10, 32'h2);
    // both limit inputs in turn, with the overtravel field set to brake at standstill
    for (int i = 2; i < 4; i++) begin
      set(i, 1'h1);
      settle(10);
      chk_st(6'h1F, 6'h0A);
      set(i, 1'h0);
      settle(15);
      chk_st(6'h10, 6'h10);
    end
    wr(8'h08, 32'h0);
    wr(8'h14, 32'h0);
    set(4, 1'h0);
    settle(10);
    chk_st(6'h32, 6'h02);
    chk_rd(8'h10, 32'h4);
    tally_and_finish();
  end
endmodule // seb_sequencer_tb
`default_nettype wire
